/* rtl/swd_link_pkg.sv */
// constants and types shared by the single-wire debug link
package swd_link_pkg;
  localparam logic [3:0] OP_SHORT_RD = 4'h8;
  localparam logic [3:0] OP_SHORT_WR = 4'h9;
  localparam logic [3:0] OP_LONG_RD = 4'ha;
  localparam logic [3:0] OP_LONG_WR = 4'hb;
  localparam logic [3:0] OP_MEM_CRC = 4'he;
  // auto-baud character spans eight bit times between the measured rising edges
  localparam int AB_SHIFT = 3;
  // memory checksum works on 4K blocks
  localparam int BLOCK_SHIFT = 12;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'h00;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  localparam logic [3:0] BITS_8N1 = 4'ha;
  localparam logic [3:0] BITS_9N1 = 4'hb;
  localparam logic [1:0] TAIL_FRAME = 2'h1;
  localparam logic [1:0] TAIL_CHECKSUM = 2'h3;
  localparam logic [1:0] TAIL_SUM_HI = 2'h2;
  typedef enum logic [3:0] {
    P_BAUD, P_CMD, P_SIZE, P_ZERO, P_A2, P_A1, P_A0, P_RDREQ, P_RDWAIT,
    P_WRDATA, P_CRCREQ, P_CRCWAIT, P_TAIL, P_TXWAIT
  } phase_e;
endpackage

/* rtl/single_wire_debug_link.sv */
// single-wire debug link: auto-baud, line drive, framing and memory commands
// Notes on behaviour
// - the auto-baud detector times from the rising edge that ends the start bit to the one that starts the stop bit
// - after the auto-baud character the measured value divided by eight becomes the baud reload and sets the bit clock
// - with output enable set and drive high clear the wire is driven both high and low while transmitting
// - with drive high set the wire is pulled high briefly for each transmitted one
// - with both output enable and drive high set each one is driven high for exactly one clock
// - with only drive high set a one is driven high until the wire reads high or mid-bit, whichever first
// - the high drive strength control switches the pin driver into high-drive mode
// - in 9-bit mode every character sent carries a ninth data bit supplied by software; each received ninth bit is reported
// - short read takes opcode 1000 with size, two address bytes, sign-extends and returns size+1 bytes and a CRC
// - short write takes opcode 1001, two address bytes and size+1 data bytes, stores them and returns a CRC
// - long read or write (1010/1011) takes 12 size bits, a zero byte, 3 address bytes, up to 4096 bytes, a CRC
// - the memory checksum command computes a checksum over the requested region and returns it
// - the checksum opcode 1110 carries a 12-bit count of 4K blocks starting at the given address with its low 12 bits cleared
`timescale 1ns/100ps
module single_wire_debug_link #(
  parameter int BAUD_W = 16,
  parameter logic [15:0] BAUD_INIT = 16'h0010
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic highDrive,
  input wire logic outputEnable,
  input wire logic driveHigh,
  input wire logic highDriveEn,
  input wire logic nineBitMode,
  input wire logic txNinth,
  output logic rxNinth,
  output logic frameError,
  output logic autoBaudDone,
  output logic [BAUD_W-1:0] baudReload,
  output logic [23:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWe,
  output logic memRe,
  input wire logic [7:0] memRdData
);
  localparam int REM_W = 25;
  localparam int AB_W = BAUD_W + swd_link_pkg::AB_SHIFT;

  typedef struct packed {
    swd_link_pkg::phase_e ph;
    logic [BAUD_W-1:0] baud;
    logic [1:0] abStep;
    logic [AB_W-1:0] abCnt;
    logic abDone;
    logic prevIn;
    logic rxOn;
    logic [BAUD_W-1:0] rxCnt;
    logic [3:0] rxIdx;
    logic [8:0] rxSh;
    logic rxNinth;
    logic frameErr;
    logic txOn;
    logic [BAUD_W-1:0] txCnt;
    logic [3:0] txIdx;
    logic [10:0] txSh;
    logic boost;
    logic [3:0] op;
    logic [11:0] size;
    logic [23:0] addr;
    logic [REM_W-1:0] rem;
    logic [7:0] crc8;
    logic [15:0] crc16;
    logic [1:0] tail;
    logic memRe;
    logic memWe;
    logic [23:0] memA;
    logic [7:0] memD;
  } state_s;

  state_s r;
  state_s n;
  logic rxDone;
  logic [7:0] rxByte;
  logic [3:0] nBits;
  logic isShort;

  function automatic logic [7:0] crc8Step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ swd_link_pkg::CRC8_POLY) : (x << 1);
    end
    return x;
  endfunction

  function automatic logic [15:0] crc16Step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ swd_link_pkg::CRC16_POLY) : (x << 1);
    end
    return x;
  endfunction

  function automatic logic [10:0] txFrame(input logic nine, input logic ninth, input logic [7:0] b);
    return nine ? {1'b1, ninth, b, 1'b0} : {2'b11, b, 1'b0};
  endfunction

  assign nBits = nineBitMode ? swd_link_pkg::BITS_9N1 : swd_link_pkg::BITS_8N1;
  assign isShort = (r.op == swd_link_pkg::OP_SHORT_RD) || (r.op == swd_link_pkg::OP_SHORT_WR);

  always_comb begin
    logic rise;
    logic fall;
    logic sendReq;
    logic [7:0] sendByte;
    rise = pinIn & ~r.prevIn;
    fall = ~pinIn & r.prevIn;
    sendReq = 1'b0;
    sendByte = 8'h00;
    n = r;
    n.prevIn = pinIn;
    n.abDone = 1'b0;
    n.frameErr = 1'b0;
    n.memRe = 1'b0;
    n.memWe = 1'b0;
    rxDone = 1'b0;
    rxByte = nineBitMode ? r.rxSh[7:0] : r.rxSh[8:1];

    // auto-baud: wait for the start bit, then time three rising edges apart
    if (r.ph == swd_link_pkg::P_BAUD) begin
      n.abCnt = r.abCnt + 1'b1;
      unique case (r.abStep)
        2'd0: if (fall) n.abStep = 2'd1;
        2'd1: if (rise) begin
          n.abStep = 2'd2;
          n.abCnt = AB_W'(1);
        end
        2'd2: if (rise) n.abStep = 2'd3;
        2'd3: if (rise) begin
          n.baud = BAUD_W'(r.abCnt >> swd_link_pkg::AB_SHIFT);
          n.abDone = 1'b1;
          n.abStep = 2'd0;
          n.ph = swd_link_pkg::P_CMD;
        end
      endcase
    end else if (!r.rxOn && !r.txOn && fall) begin
      // half duplex: own transmissions are never received
      n.rxOn = 1'b1;
      n.rxCnt = r.baud >> 1;
      n.rxIdx = 4'h0;
    end else if (r.rxOn) begin
      if (r.rxCnt == '0) begin
        n.rxCnt = r.baud - 1'b1;
        n.rxIdx = r.rxIdx + 1'b1;
        if (r.rxIdx == 4'h0) begin
          n.rxOn = ~pinIn;
        end else if (r.rxIdx == nBits - 1'b1) begin
          n.rxOn = 1'b0;
          n.frameErr = ~pinIn;
          rxDone = pinIn;
          n.rxNinth = r.rxSh[8];
        end else begin
          n.rxSh = {pinIn, r.rxSh[8:1]};
        end
      end else begin
        n.rxCnt = r.rxCnt - 1'b1;
      end
    end

    // command framing
    unique case (r.ph)
      swd_link_pkg::P_BAUD: ;
      swd_link_pkg::P_CMD: if (rxDone) begin
        n.op = rxByte[7:4];
        n.size = {8'h00, rxByte[3:0]};
        n.crc8 = crc8Step(swd_link_pkg::CRC8_INIT, rxByte);
        if (rxByte[7:4] == swd_link_pkg::OP_SHORT_RD || rxByte[7:4] == swd_link_pkg::OP_SHORT_WR) begin
          n.ph = swd_link_pkg::P_A1;
        end else if (rxByte[7:4] == swd_link_pkg::OP_LONG_RD || rxByte[7:4] == swd_link_pkg::OP_LONG_WR ||
                     rxByte[7:4] == swd_link_pkg::OP_MEM_CRC) begin
          n.ph = swd_link_pkg::P_SIZE;
        end
      end
      swd_link_pkg::P_SIZE: if (rxDone) begin
        n.size[11:4] = rxByte;
        n.crc8 = crc8Step(r.crc8, rxByte);
        n.ph = swd_link_pkg::P_ZERO;
      end
      swd_link_pkg::P_ZERO: if (rxDone) begin
        n.crc8 = crc8Step(r.crc8, rxByte);
        n.ph = swd_link_pkg::P_A2;
      end
      swd_link_pkg::P_A2: if (rxDone) begin
        n.addr[23:16] = rxByte;
        n.crc8 = crc8Step(r.crc8, rxByte);
        n.ph = swd_link_pkg::P_A1;
      end
      swd_link_pkg::P_A1: if (rxDone) begin
        n.addr[15:8] = rxByte;
        if (isShort) n.addr[23:16] = {8{rxByte[7]}};
        n.crc8 = crc8Step(r.crc8, rxByte);
        n.ph = swd_link_pkg::P_A0;
      end
      swd_link_pkg::P_A0: if (rxDone) begin
        n.crc8 = crc8Step(r.crc8, rxByte);
        n.tail = swd_link_pkg::TAIL_FRAME;
        n.rem = REM_W'(r.size) + REM_W'(1);
        n.addr[7:0] = rxByte;
        if (r.op == swd_link_pkg::OP_MEM_CRC) begin
          // low 12 address bits are don't-care: regions start on a block boundary
          n.addr[11:0] = 12'h000;
          n.rem = REM_W'(r.size) << swd_link_pkg::BLOCK_SHIFT;
          n.crc16 = swd_link_pkg::CRC16_INIT;
          n.tail = swd_link_pkg::TAIL_CHECKSUM;
          n.ph = (r.size == 12'h000) ? swd_link_pkg::P_TAIL : swd_link_pkg::P_CRCREQ;
        end else if (r.op[0]) begin
          n.ph = swd_link_pkg::P_WRDATA;
        end else begin
          n.ph = swd_link_pkg::P_RDREQ;
        end
      end
      swd_link_pkg::P_RDREQ: begin
        n.memRe = 1'b1;
        n.memA = r.addr;
        n.ph = swd_link_pkg::P_RDWAIT;
      end
      swd_link_pkg::P_RDWAIT: begin
        sendReq = 1'b1;
        sendByte = memRdData;
        n.addr = r.addr + 1'b1;
        n.rem = r.rem - 1'b1;
        n.ph = swd_link_pkg::P_TXWAIT;
      end
      swd_link_pkg::P_WRDATA: if (rxDone) begin
        n.memWe = 1'b1;
        n.memA = r.addr;
        n.memD = rxByte;
        n.addr = r.addr + 1'b1;
        n.rem = r.rem - 1'b1;
        n.crc8 = crc8Step(r.crc8, rxByte);
        if (r.rem == REM_W'(1)) n.ph = swd_link_pkg::P_TAIL;
      end
      swd_link_pkg::P_CRCREQ: begin
        n.memRe = 1'b1;
        n.memA = r.addr;
        n.ph = swd_link_pkg::P_CRCWAIT;
      end
      swd_link_pkg::P_CRCWAIT: begin
        n.crc16 = crc16Step(r.crc16, memRdData);
        n.addr = r.addr + 1'b1;
        n.rem = r.rem - 1'b1;
        n.ph = (r.rem == REM_W'(1)) ? swd_link_pkg::P_TAIL : swd_link_pkg::P_CRCREQ;
      end
      swd_link_pkg::P_TAIL: begin
        if (r.tail == 2'h0) begin
          n.ph = swd_link_pkg::P_CMD;
        end else begin
          sendReq = 1'b1;
          sendByte = (r.tail == swd_link_pkg::TAIL_CHECKSUM) ? r.crc16[7:0] :
                     (r.tail == swd_link_pkg::TAIL_SUM_HI) ? r.crc16[15:8] : r.crc8;
          n.tail = r.tail - 1'b1;
          n.ph = swd_link_pkg::P_TXWAIT;
        end
      end
      swd_link_pkg::P_TXWAIT: if (!r.txOn) begin
        n.ph = (!r.op[0] && r.op != swd_link_pkg::OP_MEM_CRC && r.rem != '0 && r.tail != 2'h0) ?
               swd_link_pkg::P_RDREQ : swd_link_pkg::P_TAIL;
      end
    endcase

    // transmitter and line drive
    if (sendReq) begin
      n.crc8 = crc8Step(r.crc8, sendByte);
      n.txOn = 1'b1;
      n.txSh = txFrame(nineBitMode, txNinth, sendByte);
      n.txIdx = 4'h0;
      n.txCnt = r.baud - 1'b1;
      n.boost = 1'b0;
    end else if (r.txOn) begin
      if (r.txCnt == '0) begin
        n.txCnt = r.baud - 1'b1;
        n.txIdx = r.txIdx + 1'b1;
        n.txSh = r.txSh >> 1;
        n.boost = driveHigh & r.txSh[1];
        if (r.txIdx == nBits - 1'b1) begin
          n.txOn = 1'b0;
          n.boost = 1'b0;
        end
      end else begin
        n.txCnt = r.txCnt - 1'b1;
        if (outputEnable) begin
          n.boost = 1'b0;
        end else if (pinIn || r.txCnt == (r.baud >> 1)) begin
          n.boost = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.baud <= BAUD_W'(BAUD_INIT);
      r.prevIn <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // a one is released to the pull-up except while boosted or under push-pull drive
  assign pinOe = r.txOn & (~r.txSh[0] | r.boost | (outputEnable & ~driveHigh));
  assign pinOut = r.txOn ? r.txSh[0] : 1'b1;
  assign highDrive = highDriveEn;
  assign rxNinth = r.rxNinth;
  assign frameError = r.frameErr;
  assign autoBaudDone = r.abDone;
  assign baudReload = r.baud;
  assign memAddr = r.memA;
  assign memWrData = r.memD;
  assign memWe = r.memWe;
  assign memRe = r.memRe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_baud_load: assert property ((r.ph == swd_link_pkg::P_BAUD && r.abStep == 2'd3 && pinIn && !r.prevIn) |=>
    (r.baud == BAUD_W'($past(r.abCnt) >> swd_link_pkg::AB_SHIFT) && autoBaudDone)) else $error("baud not loaded");
  a_push_pull: assert property ((r.txOn && outputEnable && !driveHigh) |-> pinOe)
    else $error("push-pull dropped");
  a_zero_driven: assert property ((r.txOn && !r.txSh[0]) |-> (pinOe && !pinOut))
    else $error("zero not driven");
  a_boost_one: assert property ((r.boost && outputEnable && r.txCnt != '0) |=> !r.boost)
    else $error("boost too long");
  a_boost_sense: assert property ((r.boost && !outputEnable && pinIn && r.txCnt != '0) |=> !r.boost)
    else $error("boost held after high");
  a_idle_release: assert property (!r.txOn |-> !pinOe) else $error("driving while idle");
  a_short_sext: assert property ((r.ph == swd_link_pkg::P_A1 && rxDone && isShort) |=>
    (r.addr[23:16] == {8{$past(rxByte[7])}})) else $error("address not sign extended");
  a_write_strobe: assert property ((r.ph == swd_link_pkg::P_WRDATA && rxDone) |=>
    (memWe && memWrData == $past(rxByte))) else $error("write not issued");
  a_read_send: assert property ((r.ph == swd_link_pkg::P_RDREQ) |=> memRe ##1 r.txOn)
    else $error("read data not sent");
  a_crc_fetch: assert property ((r.ph == swd_link_pkg::P_CRCREQ) |=>
    (memRe && r.ph == swd_link_pkg::P_CRCWAIT)) else $error("checksum fetch missing");
endmodule

/* test/debug_host.sv */
// debug host model: open-drain sender and listening receiver on the wire
`timescale 1ns/100ps
module debug_host #(
  parameter int P = 16
) (
  input wire logic clk,
  input wire logic wireLvl,
  input wire logic nine,
  output logic hostLow
);
  logic [8:0] rb;
  logic [8:0] q[$];
  initial hostLow = 1'b0;
  // host only pulls low; a released wire rises through the pull-up
  task automatic send(input logic [8:0] b);
    int n;
    n = nine ? 11 : 10;
    @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      hostLow = (i == 0) ? 1'b1 : (i < n - 1) ? !b[i-1] : 1'b0;
      repeat (P) @(posedge clk);
      #1;
    end
  endtask
  // own characters are skipped: the wire is half duplex
  always begin
    @(negedge wireLvl);
    if (hostLow === 1'b0) begin
      rb = 9'h000;
      repeat (P / 2) @(posedge clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (P) @(posedge clk);
        rb[i] = wireLvl;
      end
      // wait out the whole stop bit so the host never starts talking over it
      repeat (P + P / 2) @(posedge clk);
      q.push_back(rb);
    end
  end
  // a low run of several bit times reads as a character whose stop bit is low
  task automatic hold_low(input int bits);
    @(posedge clk);
    #1;
    hostLow = 1'b1;
    repeat (bits * P) @(posedge clk);
    #1;
    hostLow = 1'b0;
  endtask
  task automatic get(output logic [8:0] b, input int lim, output logic ok);
    int t;
    t = 0;
    @(posedge clk);
    #1;
    while (q.size() == 0 && t < lim) begin
      @(posedge clk);
      #1;
      t++;
    end
    ok = (q.size() != 0);
    b = ok ? q.pop_front() : 9'h000;
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the single-wire debug link
`timescale 1ns/100ps
module tb_top;
  // differs from the reset reload so that a missing auto-baud load shows
  localparam int P = 24;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic outputEnable = 1'b1;
  logic driveHigh = 1'b0;
  logic highDriveEn = 1'b0;
  logic nineBitMode = 1'b0;
  logic txNinth = 1'b0;
  logic [7:0] memRdData = 8'h00;
  logic wireLvl, hostLow, pinOut, pinOe, highDrive, rxNinth, frameError, autoBaudDone, memWe, memRe, ok;
  logic [15:0] baudReload;
  logic [23:0] memAddr, lastWa;
  logic [7:0] memWrData, lastWd, crc;
  logic [8:0] rb;
  logic abSeen = 1'b0;
  logic feSeen = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int hiRun = 0;
  int hiMax = 0;
  int weCnt = 0;
  always #2 clk = ~clk;
  // pulled-up wire: either side may pull low, the design may also drive high
  assign wireLvl = (hostLow || (pinOe && !pinOut)) ? 1'b0 : 1'b1;
  debug_host #(.P(P)) h (.clk(clk), .wireLvl(wireLvl), .nine(nineBitMode), .hostLow(hostLow));
  single_wire_debug_link dut (.clk, .rst, .pinIn(wireLvl), .pinOut, .pinOe, .highDrive, .outputEnable,
    .driveHigh, .highDriveEn, .nineBitMode, .txNinth, .rxNinth, .frameError, .autoBaudDone, .baudReload,
    .memAddr, .memWrData, .memWe, .memRe, .memRdData);
  function automatic logic [7:0] fdat(input logic [23:0] a);
    return a[7:0] ^ {a[11:8], 4'h5};
  endfunction
  function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? swd_link_pkg::CRC8_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ (c[15] ? swd_link_pkg::CRC16_POLY : 16'h0000);
    return c;
  endfunction
  // memory answers in the same cycle as the read strobe
  always @(posedge clk) begin
    #1;
    hiRun = (pinOe === 1'b1 && pinOut === 1'b1) ? hiRun + 1 : 0;
    if (hiRun > hiMax) hiMax = hiRun;
    if (autoBaudDone === 1'b1) abSeen = 1'b1;
    if (frameError === 1'b1) feSeen = 1'b1;
    if (memWe === 1'b1) begin
      weCnt++;
      lastWa = memAddr;
      lastWd = memWrData;
    end
    if (memRe === 1'b1) memRdData = fdat(memAddr);
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tx(input logic [7:0] b);
    h.send({1'b1, b});
    crc = c8(crc, b);
  endtask
  task automatic rx(output logic [7:0] b, input int lim);
    // lim counts cycles beyond twelve bit times
    h.get(rb, lim + 12 * P, ok);
    if (!ok) chk("reply present", 1, 0);
    b = rb[7:0];
    crc = c8(crc, b);
  endtask
  task automatic endc(input int lim);
    logic [7:0] e, b;
    e = crc;
    rx(b, lim);
    chk("frame crc", e, b);
  endtask
  task automatic cmd(input logic [63:0] v, input int n);
    crc = 8'h00;
    weCnt = 0;
    for (int i = n - 1; i >= 0; i--) tx(v[8*i +: 8]);
  endtask
  task automatic t_baud;
    h.send(9'h00d);
    repeat (4) @(posedge clk);
    #1;
    chk("baudReload", (8 * P) >> swd_link_pkg::AB_SHIFT, baudReload);
    chk("autoBaudDone", 1, abSeen);
  endtask
  task automatic t_frame;
    chk("frameError before break", 0, feSeen);
    h.hold_low(10);
    repeat (4) @(posedge clk);
    #1;
    chk("frameError", 1, feSeen);
  endtask
  task automatic t_swrite;
    cmd(64'h9180023cc3, 5);
    chk("write count", 2, weCnt);
    chk("write addr", 24'hff8003, lastWa);
    chk("write data", 8'hc3, lastWd);
    endc(100);
  endtask
  // one read per drive mode; a fault in the boost logic shows as a wrong high run
  task automatic t_drive;
    logic [7:0] b;
    logic [3:0] fit;
    for (int m = 0; m < 4; m++) begin
      {outputEnable, driveHigh} = m[1:0];
      highDriveEn = m[0];
      hiMax = 0;
      cmd(64'h801234, 3);
      rx(b, 100);
      chk("read data", fdat(24'h001234), b);
      endc(100);
      fit = {hiMax == 1, hiMax >= P, hiMax >= 1 && hiMax < P / 2, hiMax == 0};
      chk("high run fits mode", 1, fit[m]);
      chk("highDrive", highDriveEn, highDrive);
    end
  endtask
  task automatic t_nine;
    logic [7:0] b;
    nineBitMode = 1'b1;
    txNinth = 1'b1;
    cmd(64'h800040, 3);
    chk("rxNinth", 1, rxNinth);
    rx(b, 100);
    chk("sent ninth bit", 1, rb[8]);
    endc(100);
    nineBitMode = 1'b0;
  endtask
  task automatic t_long;
    cmd(64'hb10000123456aa55, 8);
    chk("long count", 2, weCnt);
    chk("long addr", 24'h123457, lastWa);
    chk("long data", 8'h55, lastWd);
    endc(100);
  endtask
  task automatic t_sum;
    logic [15:0] e;
    logic [7:0] lo, hi;
    e = swd_link_pkg::CRC16_INIT;
    for (int k = 0; k < 4096; k++) e = c16(e, fdat(24'h012000 + 24'(k)));
    cmd(64'he10000012000, 6);
    rx(lo, 20000);
    rx(hi, 100);
    chk("region checksum", e, {hi, lo});
    endc(100);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the slowest scenario is the checksum, about 10k cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_baud();
    t_frame();
    t_swrite();
    t_drive();
    t_nine();
    t_long();
    t_sum();
    close_out();
  end
endmodule
